// ==== bmf_pkg.sv ====
// bmf_pkg: shared constants and types for the bus-matching fifo front end
package bmf_pkg;

    localparam int BMF_DATA_W     = 36;
    localparam int BMF_WORD_W     = 18;
    localparam int BMF_BYTE_W     = 9;
    localparam int BMF_FIFO_DEPTH = 8;
    localparam int BMF_CNT_W      = $clog2(BMF_FIFO_DEPTH + 1);
    localparam int BMF_OFS_W      = 8;
    localparam int BMF_SER_BITS   = 2 * BMF_OFS_W;
    localparam int BMF_SCNT_W     = $clog2(BMF_SER_BITS + 1);

    localparam logic [BMF_OFS_W-1:0] BMF_PRESET_HI  = 8'h40;
    localparam logic [BMF_OFS_W-1:0] BMF_PRESET_MID = 8'h10;
    localparam logic [BMF_OFS_W-1:0] BMF_PRESET_LO  = 8'h08;
    localparam logic [BMF_OFS_W-1:0] BMF_OFS_RESET  = 8'h00;

    localparam logic [1:0] BMF_LAST_LONG = 2'h0;
    localparam logic [1:0] BMF_LAST_WORD = 2'h1;
    localparam logic [1:0] BMF_LAST_BYTE = 2'h3;

    typedef enum logic [1:0] {
        BMF_W_LONG = 2'h0,
        BMF_W_WORD = 2'h1,
        BMF_W_BYTE = 2'h2
    } bmf_width_e;

    typedef enum logic [2:0] {
        BMF_S_CFG    = 3'h0,
        BMF_S_MODE   = 3'h1,
        BMF_S_SERIAL = 3'h2,
        BMF_S_PROG   = 3'h3,
        BMF_S_RUN    = 3'h4
    } bmf_state_e;

endpackage

// ==== bmf_setup_rw.sv ====
// bmf_setup_rw: reset-time setup, port a write and port b read of the fifo
// Contract
// [R1] big-endian latched: high part leaves first
// [R2] little-endian latched: low part leaves first
// [R3] long-word port b ignores byte order
// [R4] timing mode sampled one edge after release; here sampled on the second edge after release, in BMF_S_MODE
// [R5] standard mode: every word needs a read
// [R6] fall-through: first word appears unrequested
// [R7] select input held static after reset
// [R8] preset offsets 64, 16 or 8 loaded
// [R9] first two writes load full, empty offsets
// [R10] parallel offset from port a low bits
// [R11] offsets kept within the legal range
// [R12] serial load, full offset first, gated
// [R13] serial load needs all offset bits
// [R14] input-ready low until serial load done
// [R15] port a drives only when selected reading
// [R16] fifo write needs full qualification
// [R17] port b drives when selected reading
// [R18] fifo read needs full qualification
// [R19] fall-through loads output when ready low
// [R20] standard mode loads output only on read
// [R21] writes and reads run independently
// [R22] reset held four clocks by host
// [R23] reset clears flags, ready after two clocks
// [R24] reserved flag patterns not applied
`timescale 1ns/1ps

module bmf_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8
) (
    input  wire logic                       clock_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       ce_i,
    input  wire logic                       in_valid_i,
    output logic                            in_ready_o,
    input  wire logic [WIDTH-1:0]           in_data_i,
    output logic                            out_valid_o,
    input  wire logic                       out_ready_i,
    output logic [WIDTH-1:0]                out_data_o,
    output logic [$clog2(DEPTH+1)-1:0]      count_o
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic             push;
    logic             pop;

    assign in_ready_o  = count_o != CW'(DEPTH);
    assign out_valid_o = count_o != '0;
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clock_i)
    begin
        if (ce_i && push)
            mem[wr_ptr] <= in_data_i;
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            count_o <= '0;
        end
        else if (ce_i)
        begin
            if (push)
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            count_o <= count_o + CW'(push) - CW'(pop);
        end
    end
endmodule // bmf_fifo

module bmf_setup_rw
    import bmf_pkg::*;
(
    input  wire logic                  clock_i,
    input  wire logic                  resetn_i,
    input  wire logic                  clock_en_i,
    input  wire logic                  byte_order_timing_select_i,
    input  wire logic                  preset_serial_select_n_i,
    input  wire logic                  flag_select0_serial_bit_i,
    input  wire logic                  flag_select1_shift_gate_n_i,
    input  wire logic [1:0]            portb_width_i,
    input  wire logic                  porta_select_n_i,
    input  wire logic                  porta_direction_i,
    input  wire logic                  a_port_transfer_gate_i,
    input  wire logic                  porta_mail_select_i,
    input  wire logic [BMF_DATA_W-1:0] porta_data_i,
    output logic      [BMF_DATA_W-1:0] porta_data_o,
    output logic                       porta_data_oe_n_o,
    input  wire logic                  portb_select_n_i,
    input  wire logic                  portb_direction_i,
    input  wire logic                  b_port_transfer_gate_i,
    input  wire logic                  portb_mail_select_i,
    output logic      [BMF_DATA_W-1:0] portb_data_o,
    output logic                       portb_data_oe_n_o,
    output logic                       full_or_input_ready_o,
    output logic                       empty_or_output_ready_o,
    output logic                       fall_through_mode_o,
    output logic                       big_endian_o,
    output logic      [BMF_OFS_W-1:0]  almost_full_offset_o,
    output logic      [BMF_OFS_W-1:0]  almost_empty_offset_o
);
    logic [1:0]             rst_sync;
    logic                   rst_n;
    bmf_state_e             state;
    bmf_state_e             next_state;
    logic                   method_par;
    logic                   method_ser;
    logic                   prog_second;
    logic [BMF_SER_BITS-1:0] ser_shift;
    logic [BMF_SCNT_W-1:0]  ser_count;
    logic                   wr_sel;
    logic                   write_ok;
    logic                   rd_sel;
    logic                   read_ok;
    logic                   push;
    logic                   pop;
    logic                   fifo_in_ready;
    logic                   fifo_valid;
    logic [BMF_DATA_W-1:0]  fifo_data;
    logic [BMF_CNT_W-1:0]   count;
    logic [BMF_CNT_W-1:0]   next_count;
    logic [BMF_DATA_W-1:0]  out_word;
    logic [1:0]             sub;
    logic [1:0]             last_idx;
    logic                   have_word;
    logic                   lanes_left;
    logic                   load_out;
    logic                   step_out;
    logic                   next_hold;
    logic                   next_lanes_left;
    bmf_width_e             width;

    function automatic logic [BMF_DATA_W-1:0] lane_of(
        input logic [BMF_DATA_W-1:0] w,
        input bmf_width_e            wd,
        input logic                  big,
        input logic [1:0]            idx
    );
        logic [1:0]            k;
        logic [BMF_DATA_W-1:0] r;
        r = '0;
        k = idx;
        case (wd)
            BMF_W_WORD:
            begin
                k = big ? BMF_LAST_WORD - idx : idx;             // R1 R2
                r[BMF_WORD_W-1:0] = w[int'(k[0]) * BMF_WORD_W +: BMF_WORD_W];
            end
            BMF_W_BYTE:
            begin
                k = big ? BMF_LAST_BYTE - idx : idx;             // R1 R2
                r[BMF_BYTE_W-1:0] = w[int'(k) * BMF_BYTE_W +: BMF_BYTE_W];
            end
            default: r = w;                                      // R3
        endcase
        return r;
    endfunction

    // release the asynchronous reset through two flops
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    assign width    = (portb_width_i == BMF_W_WORD) ? BMF_W_WORD :
                      (portb_width_i == BMF_W_BYTE) ? BMF_W_BYTE : BMF_W_LONG;
    assign last_idx = (width == BMF_W_WORD) ? BMF_LAST_WORD :
                      (width == BMF_W_BYTE) ? BMF_LAST_BYTE : BMF_LAST_LONG;

    assign wr_sel   = !porta_select_n_i && porta_direction_i &&
                      a_port_transfer_gate_i && !porta_mail_select_i;
    assign write_ok = wr_sel && full_or_input_ready_o;               // R16
    assign push     = write_ok && state == BMF_S_RUN;                // R9
    assign rd_sel   = !portb_select_n_i && portb_direction_i &&
                      b_port_transfer_gate_i && !portb_mail_select_i;
    assign read_ok  = rd_sel && empty_or_output_ready_o;             // R18

    assign lanes_left = have_word && sub != last_idx;
    // fall-through pulls a word whenever the output register is stale
    assign load_out = fifo_valid &&
                      ((fall_through_mode_o && !empty_or_output_ready_o) ||
                       (read_ok && !lanes_left));                    // R5 R6 R19 R20
    assign step_out = read_ok && lanes_left;
    assign pop      = load_out;

    bmf_fifo #(
        .WIDTH (BMF_DATA_W),
        .DEPTH (BMF_FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n),
        .ce_i        (clock_en_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (porta_data_i),
        .out_valid_o (fifo_valid),
        .out_ready_i (pop),
        .out_data_o  (fifo_data),
        .count_o     (count)
    );                                                               // R21

    always_comb
    begin
        next_state = state;
        unique case (state)
            BMF_S_CFG:    next_state = BMF_S_MODE;
            BMF_S_MODE:   next_state = method_par ? BMF_S_PROG :
                                       method_ser ? BMF_S_SERIAL : BMF_S_RUN;
            BMF_S_SERIAL: if (ser_count == BMF_SCNT_W'(BMF_SER_BITS))
                              next_state = BMF_S_RUN;
            BMF_S_PROG:   if (write_ok && prog_second)
                              next_state = BMF_S_RUN;
            BMF_S_RUN:    next_state = BMF_S_RUN;
            default:      next_state = BMF_S_CFG;
        endcase
    end

    always_comb
    begin
        next_count      = count + BMF_CNT_W'(push) - BMF_CNT_W'(pop);
        next_hold       = empty_or_output_ready_o;
        next_lanes_left = lanes_left;
        if (load_out)
        begin
            next_hold       = 1'b1;
            next_lanes_left = last_idx != BMF_LAST_LONG;
        end
        else if (step_out)
            next_lanes_left = (sub + 2'h1) != last_idx;
        else if (read_ok && fall_through_mode_o)
            next_hold = 1'b0;
    end

    // configuration straps are caught on the first edges after release
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state                 <= BMF_S_CFG;
            big_endian_o          <= 1'b0;
            fall_through_mode_o   <= 1'b0;
            method_par            <= 1'b0;
            method_ser            <= 1'b0;
            prog_second           <= 1'b0;
            ser_shift             <= '0;
            ser_count             <= '0;
            almost_full_offset_o  <= BMF_OFS_RESET;
            almost_empty_offset_o <= BMF_OFS_RESET;
        end
        else if (clock_en_i)
        begin
            state <= next_state;
            unique case (state)
                BMF_S_CFG:
                begin
                    big_endian_o <= byte_order_timing_select_i;  // R1 R2
                    method_par <= preset_serial_select_n_i &&
                                  !flag_select1_shift_gate_n_i &&
                                  !flag_select0_serial_bit_i;    // R9
                    method_ser <= !preset_serial_select_n_i &&
                                  flag_select1_shift_gate_n_i &&
                                  !flag_select0_serial_bit_i;    // R12
                    if (preset_serial_select_n_i)
                    begin
                        if (flag_select1_shift_gate_n_i &&
                            flag_select0_serial_bit_i)
                        begin
                            almost_full_offset_o  <= BMF_PRESET_HI;  // R8
                            almost_empty_offset_o <= BMF_PRESET_HI;
                        end
                        else if (flag_select1_shift_gate_n_i)
                        begin
                            almost_full_offset_o  <= BMF_PRESET_MID; // R8
                            almost_empty_offset_o <= BMF_PRESET_MID;
                        end
                        else if (flag_select0_serial_bit_i)
                        begin
                            almost_full_offset_o  <= BMF_PRESET_LO;  // R8
                            almost_empty_offset_o <= BMF_PRESET_LO;
                        end
                    end
                end
                BMF_S_MODE:
                    fall_through_mode_o <= !byte_order_timing_select_i; // R4
                BMF_S_SERIAL:
                begin
                    if (ser_count == BMF_SCNT_W'(BMF_SER_BITS))
                    begin
                        almost_full_offset_o  <=
                            ser_shift[BMF_SER_BITS-1:BMF_OFS_W];     // R12
                        almost_empty_offset_o <= ser_shift[BMF_OFS_W-1:0];
                    end
                    else if (!flag_select1_shift_gate_n_i)
                    begin
                        ser_shift <= {ser_shift[BMF_SER_BITS-2:0],
                                      flag_select0_serial_bit_i};    // R12
                        ser_count <= ser_count + 1'b1;
                    end
                end
                BMF_S_PROG:
                    if (write_ok)
                    begin
                        prog_second <= 1'b1;
                        if (prog_second)
                            almost_empty_offset_o <=
                                porta_data_i[BMF_OFS_W-1:0];         // R9 R10
                        else
                            almost_full_offset_o <=
                                porta_data_i[BMF_OFS_W-1:0];         // R9 R10
                    end
                BMF_S_RUN: ;
                default: ;
            endcase
        end
    end

    // input-ready only rises once a state that accepts writes is reached
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            full_or_input_ready_o <= 1'b0;                           // R23
        else if (clock_en_i)
            full_or_input_ready_o <= (next_state == BMF_S_PROG ||
                                      next_state == BMF_S_RUN) &&
                                     next_count <
                                     BMF_CNT_W'(BMF_FIFO_DEPTH);     // R14 R23
    end

    // output register and port b lane walk
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            empty_or_output_ready_o <= 1'b0;                         // R23
            out_word                <= '0;
            sub                     <= 2'h0;
            have_word               <= 1'b0;
            portb_data_o            <= '0;
        end
        else if (clock_en_i)
        begin
            if (load_out)
            begin
                out_word     <= fifo_data;
                sub          <= 2'h0;
                have_word    <= 1'b1;
                portb_data_o <= lane_of(fifo_data, width, big_endian_o,
                                        2'h0);
            end
            else if (step_out)
            begin
                sub          <= sub + 2'h1;
                portb_data_o <= lane_of(out_word, width, big_endian_o,
                                        sub + 2'h1);
            end
            empty_or_output_ready_o <= fall_through_mode_o ? next_hold :
                                       (next_lanes_left ||
                                        next_count != '0);
        end
    end

    // pin enables follow the selects one edge later
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            porta_data_oe_n_o <= 1'b1;
            portb_data_oe_n_o <= 1'b1;
            porta_data_o      <= '0;
        end
        else if (clock_en_i)
        begin
            porta_data_oe_n_o <= porta_select_n_i || porta_direction_i; // R15
            portb_data_oe_n_o <= portb_select_n_i || !portb_direction_i;// R17
            porta_data_o      <= '0;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n);

    // the release edge itself still runs the reset branch, so skip it
    a_preset_hi_load: assert property ( // R8
        rst_n && clock_en_i && state == BMF_S_CFG &&
        preset_serial_select_n_i &&
        flag_select1_shift_gate_n_i && flag_select0_serial_bit_i
        |=> almost_full_offset_o == BMF_PRESET_HI &&
            almost_empty_offset_o == BMF_PRESET_HI)
        else $error("preset offset not loaded");
    a_mode_latch: assert property ( // R4
        clock_en_i && state == BMF_S_MODE
        |=> fall_through_mode_o == !$past(byte_order_timing_select_i))
        else $error("timing mode not latched");
    a_serial_ir_low: assert property ( // R14
        state == BMF_S_SERIAL |-> !full_or_input_ready_o)
        else $error("input ready high during serial load");
    a_serial_done_ir: assert property ( // R14
        clock_en_i && state == BMF_S_SERIAL &&
        ser_count == BMF_SCNT_W'(BMF_SER_BITS)
        |=> full_or_input_ready_o && state == BMF_S_RUN)
        else $error("input ready not raised after serial load");
    a_parallel_first: assert property ( // R9
        clock_en_i && state == BMF_S_PROG && write_ok && !prog_second
        |=> almost_full_offset_o == $past(porta_data_i[BMF_OFS_W-1:0]) &&
            count == '0)
        else $error("first parallel write mishandled");
    a_write_count: assert property ( // R16
        clock_en_i && push && !pop |=> count == $past(count) + 1'b1)
        else $error("qualified write not stored");
    a_porta_tristate: assert property ( // R15
        rst_n && clock_en_i |=> porta_data_oe_n_o ==
            $past(porta_select_n_i || porta_direction_i))
        else $error("port a enable wrong");
    a_portb_tristate: assert property ( // R17
        rst_n && clock_en_i |=> portb_data_oe_n_o ==
            $past(portb_select_n_i || !portb_direction_i))
        else $error("port b enable wrong");
    a_std_no_read: assert property ( // R20
        clock_en_i && !fall_through_mode_o && state == BMF_S_RUN && !rd_sel
        |=> $stable(portb_data_o))
        else $error("output changed without read");
    a_fall_through: assert property ( // R19
        clock_en_i && fall_through_mode_o && !empty_or_output_ready_o &&
        fifo_valid && width == BMF_W_LONG
        |=> empty_or_output_ready_o && portb_data_o == $past(fifo_data))
        else $error("first word did not fall through");
    a_big_first: assert property ( // R1
        clock_en_i && load_out && width == BMF_W_WORD && big_endian_o
        |=> portb_data_o[BMF_WORD_W-1:0] ==
            $past(fifo_data[BMF_DATA_W-1:BMF_WORD_W]))
        else $error("big-endian order wrong");
    a_reset_flags: assert property ( // R23
        state == BMF_S_CFG |-> !full_or_input_ready_o &&
                               !empty_or_output_ready_o)
        else $error("flags not low after reset");

    c_serial_done: cover property (
        state == BMF_S_SERIAL ##1 state == BMF_S_RUN);
    c_parallel_done: cover property (
        state == BMF_S_PROG ##1 state == BMF_S_RUN);
    c_fall_through: cover property (
        fall_through_mode_o && load_out && !empty_or_output_ready_o);
    c_byte_walk: cover property (
        width == BMF_W_BYTE && step_out && sub == 2'h2);
endmodule // bmf_setup_rw

// ==== bmf_reader_model.sv ====
// bmf_reader_model: port b reading master with random stalls
`timescale 1ns/1ps

module bmf_reader_model (
    input  wire logic        clock_i,
    input  wire logic        go_i,
    input  wire logic        fall_through_i,
    input  wire logic        ready_i,
    input  wire logic [35:0] data_i,
    output logic             select_n_o,
    output logic             gate_o
);
    logic        take = 1'b0;
    logic [35:0] q[$];

    initial gate_o = 1'b0;
    assign select_n_o = ~go_i;

    // fall-through shows the word before the read consumes it
    always @(posedge clock_i)
    begin
        take <= !select_n_o && gate_o && ready_i;
        if (!select_n_o && gate_o && ready_i && fall_through_i)
            q.push_back(data_i);
    end

    always @(negedge clock_i)
    begin
        if (take && !fall_through_i)
            q.push_back(data_i);
        gate_o <= go_i && ($urandom_range(3, 0) != 0);
    end
endmodule // bmf_reader_model

// ==== bmf_setup_rw_test.sv ====
// bmf_setup_rw_test: self-checking bench for the fifo setup and ports
`timescale 1ns/1ps

module bmf_setup_rw_test;
    logic        clk = 0, rst_n = 0, bo = 0, preset_serial_select_n = 0, f0 = 0, f1 = 0;
    logic        a_sel_n = 0, a_dir = 1, a_gate = 0, a_mail = 0, go = 0;
    logic [1:0]  wd = 0;
    logic        ce = 1, b_dir = 1;
    logic [35:0] a_d = 0, pa_q, pb_q;
    logic        pa_oe_n, pb_oe_n, ir, orf, ft, be, pb_sel_n, pb_gate;
    logic [7:0]  af_o, ae_o;
    logic [35:0] exp_q[$];
    logic [5:0]  cfg[5] = '{6'h3D, 6'h3A, 6'h34, 6'h11, 6'h08};
    int          n_fail = 0, compares = 0, cyc = 0, nw = 1;

    bmf_setup_rw dut (.clock_i(clk), .resetn_i(rst_n), .clock_en_i(ce),
        .byte_order_timing_select_i(bo), .preset_serial_select_n_i(preset_serial_select_n),
        .flag_select0_serial_bit_i(f0), .flag_select1_shift_gate_n_i(f1),
        .portb_width_i(wd), .porta_select_n_i(a_sel_n),
        .porta_direction_i(a_dir), .a_port_transfer_gate_i(a_gate),
        .porta_mail_select_i(a_mail), .porta_data_i(a_d),
        .porta_data_o(pa_q), .porta_data_oe_n_o(pa_oe_n),
        .portb_select_n_i(pb_sel_n), .portb_direction_i(b_dir),
        .b_port_transfer_gate_i(pb_gate), .portb_mail_select_i(1'b0),
        .portb_data_o(pb_q), .portb_data_oe_n_o(pb_oe_n),
        .full_or_input_ready_o(ir), .empty_or_output_ready_o(orf),
        .fall_through_mode_o(ft), .big_endian_o(be),
        .almost_full_offset_o(af_o), .almost_empty_offset_o(ae_o));

    bmf_reader_model p (.clock_i(clk), .go_i(go), .fall_through_i(ft),
        .ready_i(orf), .data_i(pb_q), .select_n_o(pb_sel_n),
        .gate_o(pb_gate));

    initial forever #5 clk = ~clk;

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            results;
        end
    end

    task automatic chk(input logic [35:0] seen, input logic [35:0] want);
        compares++;
        if (seen !== want)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask

    function automatic logic [35:0] lane(input logic [35:0] w, input int i);
        int k;
        int b;
        k = bo ? nw - 1 - i : i;
        b = 36 / nw;
        return (w >> (k * b)) & ((36'h1 << b) - 36'h1);
    endfunction

    // only a word the port can take is expected back
    task automatic wr(input logic [35:0] d, input logic m, input bit st);
        @(negedge clk);
        a_gate = 1;
        a_mail = m;
        a_d = d;
        if (ir === 1'b1 && !m && st)
            for (int i = 0; i < nw; i++)
                exp_q.push_back(lane(d, i));
        @(posedge clk);
    endtask

    task automatic idle;
        @(negedge clk);
        a_gate = 0;
    endtask

    task automatic run(input int t);
        logic [7:0]  af;
        logic [7:0]  ae;
        logic [15:0] sb;
        // straps only move while reset is held; f0 and f1 also carry the serial load after release
        go = 0;
        rst_n = 0;
        {bo, preset_serial_select_n, f1, f0, wd} = cfg[t];
        nw = wd == 1 ? 2 : wd == 2 ? 4 : 1;
        af = 8'($urandom_range(252, 1));
        ae = 8'($urandom_range(252, 1));
        if (preset_serial_select_n && (f1 || f0))
            af = f1 && f0 ? 8'h40 : f1 ? 8'h10 : 8'h08;
        if (preset_serial_select_n && (f1 || f0))
            ae = af;
        repeat (20) @(negedge clk);
        rst_n = 1;
        repeat (10) @(negedge clk);
        chk(be, bo);
        chk(ft, !bo);
        chk(ir, preset_serial_select_n);
        sb = {af, ae};
        for (int i = 15; i >= 0 && !preset_serial_select_n; i--)
        begin
            @(negedge clk);
            f0 = sb[i];
            f1 = 0;
            chk(ir, 0);
        end
        if (!preset_serial_select_n)
        begin
            @(negedge clk);
            f1 = 1;
            chk(ir, 0);
            @(negedge clk);
            chk(ir, 1);
        end
        if (preset_serial_select_n && !f1 && !f0)
        begin
            wr({28'($urandom), af}, 0, 0);
            wr({28'($urandom), ae}, 0, 0);
        end
        idle;
        chk(af_o, af);
        chk(ae_o, ae);
        a_d = {4'($urandom), $urandom};
        wr(a_d, 0, 1);
        idle;
        repeat (4) @(negedge clk);
        chk(pb_q, bo ? 36'h0 : lane(a_d, 0));
        a_dir = 0;
        // a low clock enable must freeze the registered pin enable
        ce = 0;
        repeat (2) @(negedge clk);
        chk(pa_oe_n, 1);
        ce = 1;
        repeat (2) @(negedge clk);
        chk(pa_oe_n, 0);
        chk(pa_q, 36'h0);
        a_sel_n = 1;
        repeat (2) @(negedge clk);
        chk(pa_oe_n, 1);
        a_sel_n = 0;
        a_dir = 1;
        chk(pb_oe_n, 1);
        for (int i = 0; i < 11; i++)
            wr({4'($urandom), $urandom}, i == 3, 1);
        idle;
        chk(ir, 0);
        go = 1;
        for (int i = 0; i < 6; i++)
            wr({4'($urandom), $urandom}, 0, 1);
        idle;
        chk(pb_oe_n, 0);
        for (int i = 0; i < 600 && p.q.size() < exp_q.size(); i++)
            @(negedge clk);
        chk(36'(p.q.size()), 36'(exp_q.size()));
        while (exp_q.size() > 0 && p.q.size() > 0)
            chk(p.q.pop_front(), exp_q.pop_front());
        b_dir = 0;
        repeat (2) @(negedge clk);
        chk(pb_oe_n, 1);
        b_dir = 1;
        exp_q.delete();
        p.q.delete();
        go = 0;
        $display("test %0d done", t);
    endtask

    task automatic results;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        void'($urandom(32'hA4B4));
        for (int t = 0; t < 5; t++)
            run(t);
        results;
    end
endmodule // bmf_setup_rw_test
